// ==== pin_cfg_map.svh ====
// Offsets, field positions, reset values and direction encoding of the port block.
// Assumes a 32-bit APB where register index n sits at byte address 4*n.
`ifndef PIN_CFG_MAP_SVH
`define PIN_CFG_MAP_SVH

// Register indices; byte address is four times the index
`define PCFG_IDX_DATA 30'h0000F220
`define PCFG_IDX_DIR 30'h0000F221
`define PCFG_IDX_CODE_LO 30'h0000F222
`define PCFG_IDX_CODE_HI 30'h0000F223

// Byte lanes
`define PCFG_LANE_LO 0
`define PCFG_LANE_HI 1

// Reset values
`define PCFG_RST_DATA 8'h00
`define PCFG_RST_DIR 8'h00
`define PCFG_RST_CODE 8'h00

// Direction encoding
`define PCFG_DIR_OUT 1'h0
`define PCFG_DIR_IN 1'h1

`define PCFG_PINS 8
`define PCFG_RD_ZERO 32'h00000000

`endif

// ==== pin_cfg_pkg.sv ====
// Types shared by the port configuration block.
// Assumes the constants of pin_cfg_map.svh.
package pin_cfg_pkg;

  typedef enum logic [1:0] {
    DRV_HIZ,
    DRV_PCH_OD,
    DRV_NCH_OD,
    DRV_CMOS
  } drive_mode_t;

  typedef enum logic [1:0] {
    TERM_HIZ,
    TERM_PULL_DOWN,
    TERM_PULL_UP
  } term_mode_t;

endpackage : pin_cfg_pkg

// ==== pin_input_sample.sv ====
// Registers the eight port pin levels for reads of the data register.
// Assumes pin levels are already synchronous to ref_clk.
`timescale 1ns/100ps
`include "pin_cfg_map.svh"

module pin_input_sample (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic [7:0] pad_in,
  output logic [7:0] level_r
);

  logic [7:0] level_nxt;

  always_comb begin
    level_nxt = pad_in;
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      level_r <= `PCFG_RST_DATA;
    end else begin
      level_r <= level_nxt;
    end
  end

  // One cycle of latency, so a read shows the level of the prior edge
  AST_SAMPLE_FOLLOWS: assert property (@(posedge ref_clk) disable iff (!nrst)
    nrst |=> level_r == $past(pad_in))
    else $error("sampled level does not follow pad");

endmodule : pin_input_sample

// ==== pin_drive_cell.sv ====
// Driver and termination decode for one port pin, registered.
// Assumes direction, data and code bits come from the register file.
`timescale 1ns/100ps
`include "pin_cfg_map.svh"

module pin_drive_cell (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic dir,
  input wire logic data,
  input wire logic code_lo,
  input wire logic code_hi,
  output logic pad_out_r,
  output logic pad_oe_r,
  output logic pull_up_r,
  output logic pull_down_r
);

  pin_cfg_pkg::drive_mode_t drv;
  pin_cfg_pkg::term_mode_t term;
  logic pad_out_nxt;
  logic pad_oe_nxt;
  logic pull_up_nxt;
  logic pull_down_nxt;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    drv = pin_cfg_pkg::DRV_HIZ;
    term = pin_cfg_pkg::TERM_HIZ;
    pad_out_nxt = 1'h0;
    pad_oe_nxt = 1'h0;
    if (dir == `PCFG_DIR_OUT) begin
      case ({code_hi, code_lo})
        2'h1: drv = pin_cfg_pkg::DRV_PCH_OD;
        2'h2: drv = pin_cfg_pkg::DRV_NCH_OD;
        2'h3: drv = pin_cfg_pkg::DRV_CMOS;
        default: drv = pin_cfg_pkg::DRV_HIZ;
      endcase
    end else begin
      case ({code_hi, code_lo})
        2'h1: term = pin_cfg_pkg::TERM_PULL_DOWN;
        2'h2: term = pin_cfg_pkg::TERM_PULL_UP;
        default: term = pin_cfg_pkg::TERM_HIZ;
      endcase
    end
    case (drv)
      pin_cfg_pkg::DRV_PCH_OD: begin
        pad_out_nxt = 1'h1;
        pad_oe_nxt = data;
      end
      pin_cfg_pkg::DRV_NCH_OD: begin
        pad_out_nxt = 1'h0;
        pad_oe_nxt = ~data;
      end
      pin_cfg_pkg::DRV_CMOS: begin
        pad_out_nxt = data;
        pad_oe_nxt = 1'h1;
      end
      default: begin
        pad_out_nxt = 1'h0;
        pad_oe_nxt = 1'h0;
      end
    endcase
    pull_up_nxt = (term == pin_cfg_pkg::TERM_PULL_UP);
    pull_down_nxt = (term == pin_cfg_pkg::TERM_PULL_DOWN);
  end

  // Reset leaves the pin floating, no pulls
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      pad_out_r <= 1'h0;
      pad_oe_r <= 1'h0;
      pull_up_r <= 1'h0;
      pull_down_r <= 1'h0;
    end else begin
      pad_out_r <= pad_out_nxt;
      pad_oe_r <= pad_oe_nxt;
      pull_up_r <= pull_up_nxt;
      pull_down_r <= pull_down_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  AST_OUT_HIZ: assert property (!dir && !code_hi && !code_lo |=>
    !pad_oe_r && !pull_up_r && !pull_down_r)
    else $error("hi-z output drives or pulls");
  AST_PCH_OD: assert property (!dir && !code_hi && code_lo |=>
    pad_out_r && pad_oe_r == $past(data))
    else $error("p-channel open drain wrong");
  AST_NCH_OD: assert property (!dir && code_hi && !code_lo |=>
    !pad_out_r && pad_oe_r == !$past(data))
    else $error("n-channel open drain wrong");
  AST_CMOS: assert property (!dir && code_hi && code_lo |=>
    pad_oe_r && pad_out_r == $past(data))
    else $error("cmos output wrong");
  AST_IN_TERM: assert property (dir |=> !pad_oe_r &&
    pull_up_r == ($past(code_hi) && !$past(code_lo)) &&
    pull_down_r == (!$past(code_hi) && $past(code_lo)))
    else $error("input termination wrong");
  AST_DIR_SPLIT: assert property (!dir |=>
    !pull_up_r && !pull_down_r)
    else $error("output mode enables a pull");

endmodule : pin_drive_cell

// ==== port_pin_drive_pull_config.sv ====
// Functional notes
// - Two 8-bit code registers; bit n of each forms pin n code.
// - Pin direction bit chooses driver reading or termination reading.
// - Output codes: 00 hi-z, 01 p-open drain, 10 n-open drain, 11 CMOS.
// - Input codes: 00 hi-z, 01 pull-down, 10 pull-up, 11 hi-z.
// - Both code registers read and write fully, reset to zero.
// - Byte access to either register; 16-bit access at the low one.
// - Direction 0 is output and the reset state; 1 is input.
// - Output drives the data bit; input reads return pin level.
// - After reset every pin is output with hi-z driver.
//
// Top of the 8-pin port: APB slave, data, direction and code registers.
// Assumes APB4 on ref_clk and pin levels synchronous to ref_clk.
`timescale 1ns/100ps
`include "pin_cfg_map.svh"

module port_pin_drive_pull_config (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:0] pad_in,
  output logic [7:0] pad_out,
  output logic [7:0] pad_oe,
  output logic [7:0] pull_up_en,
  output logic [7:0] pull_down_en
);

  ////////////////////////////////////////////////////////////////////////////
  // Address decode shared by read and write paths
  function automatic logic hit(input logic [31:0] addr,
                               input logic [29:0] idx);
    hit = (addr[31:2] == idx) && (addr[1:0] == 2'h0);
  endfunction : hit

  function automatic logic mapped(input logic [31:0] addr);
    mapped = hit(addr, `PCFG_IDX_DATA) || hit(addr, `PCFG_IDX_DIR) ||
             hit(addr, `PCFG_IDX_CODE_LO) || hit(addr, `PCFG_IDX_CODE_HI);
  endfunction : mapped

  logic [7:0] pin_data_register_r;
  logic [7:0] pin_data_register_nxt;
  logic [7:0] pin_direction_register_r;
  logic [7:0] pin_direction_register_nxt;
  logic [7:0] pin_config_low_bits_r;
  logic [7:0] pin_config_low_bits_nxt;
  logic [7:0] pin_config_high_bits_r;
  logic [7:0] pin_config_high_bits_nxt;
  logic [31:0] prdata_r;
  logic [31:0] prdata_nxt;
  logic pready_r;
  logic pready_nxt;
  logic pslverr_r;
  logic pslverr_nxt;
  logic [7:0] level_r;
  logic setup;
  logic wr_take;
  logic [7:0] data_view;

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;

  ////////////////////////////////////////////////////////////////////////////
  // Bus handshake: answer registered in setup, so every access waits
  // exactly one cycle; costs a cycle but keeps all outputs on flops.
  always_comb begin
    setup = psel && !penable;
    wr_take = psel && penable && pready_r && pwrite && !pslverr_r;
    pready_nxt = setup;
    pslverr_nxt = setup && !mapped(paddr);
  end

  // In input mode the data register reads the pin, else the stored bit
  always_comb begin
    for (int i = 0; i < `PCFG_PINS; i++) begin
      data_view[i] = pin_direction_register_r[i] ? level_r[i]
                                                 : pin_data_register_r[i];
    end
  end

  always_comb begin
    prdata_nxt = prdata_r;
    if (setup) begin
      prdata_nxt = `PCFG_RD_ZERO;
      if (!pwrite) begin
        if (hit(paddr, `PCFG_IDX_DATA)) begin
          prdata_nxt[7:0] = data_view;
        end else if (hit(paddr, `PCFG_IDX_DIR)) begin
          prdata_nxt[7:0] = pin_direction_register_r;
        end else if (hit(paddr, `PCFG_IDX_CODE_LO)) begin
          prdata_nxt[15:0] = {pin_config_high_bits_r,
                              pin_config_low_bits_r};
        end else if (hit(paddr, `PCFG_IDX_CODE_HI)) begin
          prdata_nxt[7:0] = pin_config_high_bits_r;
        end
      end
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      prdata_r <= `PCFG_RD_ZERO;
      pready_r <= 1'h0;
      pslverr_r <= 1'h0;
    end else begin
      prdata_r <= prdata_nxt;
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register file; a word write at the low code register also
  // reaches the high one through byte lane 1.
  always_comb begin
    pin_data_register_nxt = pin_data_register_r;
    pin_direction_register_nxt = pin_direction_register_r;
    pin_config_low_bits_nxt = pin_config_low_bits_r;
    pin_config_high_bits_nxt = pin_config_high_bits_r;
    if (wr_take && pstrb[`PCFG_LANE_LO]) begin
      if (hit(paddr, `PCFG_IDX_DATA)) begin
        pin_data_register_nxt = pwdata[7:0];
      end
      if (hit(paddr, `PCFG_IDX_DIR)) begin
        pin_direction_register_nxt = pwdata[7:0];
      end
      if (hit(paddr, `PCFG_IDX_CODE_LO)) begin
        pin_config_low_bits_nxt = pwdata[7:0];
      end
      if (hit(paddr, `PCFG_IDX_CODE_HI)) begin
        pin_config_high_bits_nxt = pwdata[7:0];
      end
    end
    if (wr_take && pstrb[`PCFG_LANE_HI] &&
        hit(paddr, `PCFG_IDX_CODE_LO)) begin
      pin_config_high_bits_nxt = pwdata[15:8];
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      pin_data_register_r <= `PCFG_RST_DATA;
      pin_direction_register_r <= `PCFG_RST_DIR;
      pin_config_low_bits_r <= `PCFG_RST_CODE;
      pin_config_high_bits_r <= `PCFG_RST_CODE;
    end else begin
      pin_data_register_r <= pin_data_register_nxt;
      pin_direction_register_r <= pin_direction_register_nxt;
      pin_config_low_bits_r <= pin_config_low_bits_nxt;
      pin_config_high_bits_r <= pin_config_high_bits_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin side; changes show at the pads one edge after the write edge
  pin_input_sample u_sample (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .pad_in(pad_in),
    .level_r(level_r)
  );

  for (genvar n = 0; n < `PCFG_PINS; n++) begin : g_pin
    pin_drive_cell u_cell (
      .ref_clk(ref_clk),
      .nrst(nrst),
      .dir(pin_direction_register_r[n]),
      .data(pin_data_register_r[n]),
      .code_lo(pin_config_low_bits_r[n]),
      .code_hi(pin_config_high_bits_r[n]),
      .pad_out_r(pad_out[n]),
      .pad_oe_r(pad_oe[n]),
      .pull_up_r(pull_up_en[n]),
      .pull_down_r(pull_down_en[n])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  sequence s_setup_wr(logic [29:0] idx);
    psel && !penable && pwrite && hit(paddr, idx);
  endsequence

  sequence s_access;
    psel && penable && pready;
  endsequence

  AST_ONE_WAIT: assert property (psel && !penable |=> pready)
    else $error("pready not given one cycle after setup");
  AST_LOW_WRITE: assert property (s_setup_wr(`PCFG_IDX_CODE_LO) ##1
    (s_access and pstrb[0]) |=> pin_config_low_bits_r == $past(pwdata[7:0]))
    else $error("low code byte not written");
  AST_WORD_WRITE: assert property (s_setup_wr(`PCFG_IDX_CODE_LO) ##1
    (s_access and pstrb[1]) |=> pin_config_high_bits_r == $past(pwdata[15:8]))
    else $error("word write missed high code byte");
  AST_HIGH_WRITE: assert property (s_setup_wr(`PCFG_IDX_CODE_HI) ##1
    (s_access and pstrb[0]) |=> pin_config_high_bits_r == $past(pwdata[7:0]))
    else $error("high code byte not written");
  AST_WORD_READ: assert property (psel && !penable && !pwrite &&
    hit(paddr, `PCFG_IDX_CODE_LO) |=> prdata ==
    {16'h0000, $past(pin_config_high_bits_r), $past(pin_config_low_bits_r)})
    else $error("code word read wrong");
  AST_PIN_READ: assert property (psel && !penable && !pwrite &&
    hit(paddr, `PCFG_IDX_DATA) && pin_direction_register_r == 8'hFF
    |=> prdata[7:0] == $past(level_r))
    else $error("input mode read not pin level");
  AST_UNMAPPED: assert property (psel && !penable && !mapped(paddr)
    |=> pslverr && pready)
    else $error("unmapped address not refused");
  AST_IDLE_HIZ: assert property (pin_direction_register_r == 8'h00 &&
    pin_config_low_bits_r == 8'h00 && pin_config_high_bits_r == 8'h00
    [*2] |-> pad_oe == 8'h00 && pull_up_en == 8'h00)
    else $error("zero configuration does not float pins");

  ////////////////////////////////////////////////////////////////////////////
  // Reads compare against register contents at the setup edge,
  // since read data is captured there and then held.
  sequence s_setup_rd(logic [29:0] idx);
    psel && !penable && !pwrite && hit(paddr, idx);
  endsequence

  sequence s_refused_wr;
    psel && !penable && pwrite && !mapped(paddr);
  endsequence

  AST_READY_PULSE: assert property (pready |=> !pready)
    else $error("pready high for more than one cycle");
  AST_ERR_ONLY_READY: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  AST_MAPPED_OK: assert property (psel && !penable && mapped(paddr)
    |=> pready && !pslverr)
    else $error("mapped address refused");
  AST_MISALIGNED: assert property (psel && !penable && paddr[1:0] != 2'h0
    |=> pslverr && pready)
    else $error("misaligned address not refused");

  AST_DATA_WRITE: assert property (s_setup_wr(`PCFG_IDX_DATA) ##1
    (s_access and pstrb[0]) |=> pin_data_register_r == $past(pwdata[7:0]))
    else $error("data byte not written");
  AST_DIR_WRITE: assert property (s_setup_wr(`PCFG_IDX_DIR) ##1
    (s_access and pstrb[0]) |=>
    pin_direction_register_r == $past(pwdata[7:0]))
    else $error("direction byte not written");
  AST_LANE_LO_HOLD: assert property (s_setup_wr(`PCFG_IDX_CODE_LO) ##1
    (s_access and !pstrb[0]) |=> $stable(pin_config_low_bits_r))
    else $error("low code byte written without its strobe");
  AST_LANE_HI_HOLD: assert property (s_setup_wr(`PCFG_IDX_CODE_LO) ##1
    (s_access and !pstrb[1]) |=> $stable(pin_config_high_bits_r))
    else $error("high code byte written without its strobe");
  AST_REFUSED_WR: assert property (s_refused_wr ##1 s_access |=>
    $stable(pin_config_low_bits_r) && $stable(pin_config_high_bits_r) &&
    $stable(pin_data_register_r) && $stable(pin_direction_register_r))
    else $error("refused write changed a register");

  AST_REFUSED_RD: assert property (psel && !penable && !pwrite &&
    !mapped(paddr) |=> prdata == `PCFG_RD_ZERO)
    else $error("refused read returned data");
  AST_HIGH_READ: assert property (s_setup_rd(`PCFG_IDX_CODE_HI) |=>
    prdata == {24'h000000, $past(pin_config_high_bits_r)})
    else $error("high code byte read wrong");
  AST_DIR_READ: assert property (s_setup_rd(`PCFG_IDX_DIR) |=>
    prdata == {24'h000000, $past(pin_direction_register_r)})
    else $error("direction read wrong");
  AST_OUT_READ: assert property (s_setup_rd(`PCFG_IDX_DATA) and
    (pin_direction_register_r == 8'h00)
    |=> prdata[7:0] == $past(pin_data_register_r))
    else $error("output mode read not data register");

  // Pad-level checks over all eight pins at once
  AST_PULL_EXCL: assert property ((pull_up_en & pull_down_en) == 8'h00)
    else $error("pull-up and pull-down both on");
  AST_OUT_NO_PULL: assert property (pin_direction_register_r == 8'h00
    [*2] |-> pull_up_en == 8'h00 && pull_down_en == 8'h00)
    else $error("output mode pin has a pull");
  AST_IN_FLOAT: assert property (pin_direction_register_r == 8'hFF
    [*2] |-> pad_oe == 8'h00)
    else $error("input mode pin is driven");
  AST_CMOS_FOLLOW: assert property (pin_direction_register_r == 8'h00 &&
    pin_config_low_bits_r == 8'hFF && pin_config_high_bits_r == 8'hFF
    |=> pad_oe == 8'hFF && pad_out == $past(pin_data_register_r))
    else $error("cmos pins do not follow data");
  AST_PCH_PINS: assert property (pin_direction_register_r == 8'h00 &&
    pin_config_low_bits_r == 8'hFF && pin_config_high_bits_r == 8'h00
    |=> pad_out == 8'hFF && pad_oe == $past(pin_data_register_r))
    else $error("p-channel pins do not follow data");
  AST_NCH_PINS: assert property (pin_direction_register_r == 8'h00 &&
    pin_config_low_bits_r == 8'h00 && pin_config_high_bits_r == 8'hFF
    |=> pad_out == 8'h00 && pad_oe == ~$past(pin_data_register_r))
    else $error("n-channel pins do not follow data");
  AST_PULLUP_PINS: assert property (pin_direction_register_r == 8'hFF &&
    pin_config_low_bits_r == 8'h00 && pin_config_high_bits_r == 8'hFF
    |=> pull_up_en == 8'hFF && pull_down_en == 8'h00 && pad_oe == 8'h00)
    else $error("pull-up pins wrong");

endmodule : port_pin_drive_pull_config

// ==== pin_world.sv ====
// Model of the circuitry hung on the eight port pins.
// Assumes the block's pad outputs and the bench's optional external drive.
`timescale 1ns/100ps

module pin_world (
  input wire logic ref_clk,
  input wire logic [7:0] pad_out,
  input wire logic [7:0] pad_oe,
  input wire logic [7:0] pull_up_en,
  input wire logic [7:0] pull_down_en,
  input wire logic [7:0] ext_en,
  input wire logic [7:0] ext_level,
  output logic [7:0] pad_in
);
  logic [7:0] last_r = 8'h00;

  // A floating pin wanders: never trust a stale level
  always @(posedge ref_clk) begin
    last_r <= pad_in;
  end

  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (pad_oe[i]) pad_in[i] = pad_out[i];
      else if (ext_en[i]) pad_in[i] = ext_level[i];
      else if (pull_up_en[i]) pad_in[i] = 1'b1;
      else if (pull_down_en[i]) pad_in[i] = 1'b0;
      else pad_in[i] = ~last_r[i];
    end
  end
endmodule : pin_world

// ==== testbench.sv ====
// Self-checking bench for the port configuration block.
// Assumes APB answers one cycle after setup, pads two edges late.
`timescale 1ns/100ps
`include "pin_cfg_map.svh"

module testbench;
  localparam logic [31:0] A_DAT = {`PCFG_IDX_DATA, 2'h0};
  localparam logic [31:0] A_DIR = {`PCFG_IDX_DIR, 2'h0};
  localparam logic [31:0] A_LO = {`PCFG_IDX_CODE_LO, 2'h0};
  localparam logic [31:0] A_HI = {`PCFG_IDX_CODE_HI, 2'h0};
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [31:0] paddr = 32'h0, pwdata = 32'h0;
  logic [3:0] pstrb = 4'h0;
  logic [31:0] prdata;
  logic pready, pslverr;
  logic [7:0] pad_in, pad_out, pad_oe, pull_up_en, pull_down_en;
  logic [7:0] ext_en = 8'h00, ext_level = 8'h00;
  int miscompares = 0;
  int checks = 0;
  logic [31:0] rd;
  logic err;
  logic [15:0] out_exp [4] = '{16'h0000, 16'hF0F0, 16'h0F00, 16'hFFF0};
  logic [23:0] in_exp [4] = '{24'h0, 24'h00FF00, 24'hFF0000, 24'h0};

  always #5 ref_clk = ~ref_clk;

  port_pin_drive_pull_config port_pin_drive_pull_config_i (.ref_clk(ref_clk),
    .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pad_in(pad_in), .pad_out(pad_out),
    .pad_oe(pad_oe), .pull_up_en(pull_up_en), .pull_down_en(pull_down_en));

  pin_world pin_world_i (.ref_clk(ref_clk), .pad_out(pad_out),
    .pad_oe(pad_oe), .pull_up_en(pull_up_en), .pull_down_en(pull_down_en),
    .ext_en(ext_en), .ext_level(ext_level), .pad_in(pad_in));

  ////////////////////////////////////////////////////////////////////////////
  task report_and_stop;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : report_and_stop

  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Entered just after a rising edge; lets one idle edge pass after
  // the pready edge so that psel is never driven twice in one step
  task apb(input logic wr, input logic [31:0] a, input logic [31:0] d,
           input logic [3:0] s);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask : apb

  task settle;
    repeat (3) @(posedge ref_clk);
  endtask : settle

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge ref_clk);
    nrst <= 1'b1;
    @(posedge ref_clk);
    chk({pad_oe, pull_up_en, pull_down_en}, 32'h0);
    apb(1'b0, A_LO, 32'h0, 4'h0); chk(rd, 32'h0);
    apb(1'b0, A_HI, 32'h0, 4'h0); chk(rd, 32'h0);
    apb(1'b0, A_DIR, 32'h0, 4'h0); chk(rd, 32'h0);
    // Output mode, every code on all pins, word writes
    apb(1'b1, A_DAT, 32'hF0, 4'h1);
    for (int c = 0; c < 4; c++) begin
      apb(1'b1, A_LO, {16'h0, {8{c[1]}}, {8{c[0]}}}, 4'h3);
      settle();
      chk({pad_oe, pad_out & pad_oe}, out_exp[c]);
      chk({pull_up_en, pull_down_en}, 32'h0);
    end
    apb(1'b0, A_DAT, 32'h0, 4'h0); chk(rd, 32'hF0);
    // Input mode, same codes read as terminations
    apb(1'b1, A_DIR, 32'hFF, 4'h1);
    for (int c = 0; c < 4; c++) begin
      apb(1'b1, A_LO, {16'h0, {8{c[1]}}, {8{c[0]}}}, 4'h3);
      settle();
      chk({pull_up_en, pull_down_en, pad_oe}, in_exp[c]);
      if (c == 1 || c == 2) begin
        apb(1'b0, A_DAT, 32'h0, 4'h0); chk(rd, {24'h0, {8{c[1]}}});
      end
    end
    ext_en <= 8'hFF;
    ext_level <= 8'h5A;
    settle();
    apb(1'b0, A_DAT, 32'h0, 4'h0); chk(rd, 32'h5A);
    ext_en <= 8'h00;
    // Mixed codes per pin, byte writes, back in output mode
    apb(1'b1, A_DIR, 32'h00, 4'h1);
    apb(1'b1, A_LO, 32'h33, 4'h1);
    apb(1'b1, A_HI, 32'h55, 4'h1);
    settle();
    chk({pad_oe, pad_out & pad_oe}, 16'h3530);
    apb(1'b0, A_LO, 32'h0, 4'h0); chk(rd, 32'h5533);
    // Lane 1 only: low byte must stay
    apb(1'b1, A_LO, 32'hAAFF, 4'h2);
    apb(1'b0, A_LO, 32'h0, 4'h0); chk(rd, 32'hAA33);
    apb(1'b0, A_HI, 32'h0, 4'h0); chk(rd, 32'hAA);
    // Unmapped place refuses and leaves registers alone
    apb(1'b1, A_LO + 32'h40, 32'hFF, 4'hF); chk({31'h0, err}, 32'h1);
    apb(1'b0, A_LO + 32'h40, 32'h0, 4'h0); chk(rd, 32'h0);
    chk({31'h0, err}, 32'h1);
    apb(1'b0, A_LO + 32'h1, 32'h0, 4'h0); chk({31'h0, err}, 32'h1);
    apb(1'b0, A_LO, 32'h0, 4'h0); chk(rd, 32'hAA33);
    // Mid-run reset returns all pins to floating outputs
    nrst <= 1'b0;
    repeat (4) @(posedge ref_clk);
    nrst <= 1'b1;
    settle();
    chk({pad_oe, pull_up_en, pull_down_en}, 32'h0);
    apb(1'b0, A_LO, 32'h0, 4'h0); chk(rd, 32'h0);
    report_and_stop();
  end

  // Whole run is about 130 cycles; a stuck handshake ends here
  initial begin
    repeat (5000) @(posedge ref_clk);
    miscompares++;
    report_and_stop();
  end
endmodule : testbench
